// [design/sutm_cmd.sv]
// Command interpreter for teach, reference shift, BCD read and monitor.
// Assumes all inputs are synchronous to CORE_CLK and that an external
// scaler turns RAW_IN into SCALED_IN using the exported input points.
//
// Strobed register access and the placing of the registers were left to the implementer.
module sutm_cmd #(
   parameter int ALT_CYCLES  = sutm_pkg::ALT_CYCLES_DEF,
   parameter int NV_LIMIT    = sutm_pkg::NV_WRITE_LIMIT
) (
   input  wire logic                          CORE_CLK,
   input  wire logic                          SRST,
   input  wire logic [sutm_pkg::ADDR_W-1:0]   REG_ADDR,
   input  wire logic [sutm_pkg::WORD_W-1:0]   REG_WDATA,
   input  wire logic                          REG_WR,
   input  wire logic                          REG_RD,
   output      logic [sutm_pkg::WORD_W-1:0]   REG_RDATA,
   input  wire logic [sutm_pkg::WORD_W-1:0]   SCALED_IN,
   input  wire logic [sutm_pkg::WORD_W-1:0]   RAW_IN,
   input  wire logic                          MEAS_VALID,
   input  wire logic                          SHIFT_REF,
   input  wire logic                          REFERENCE_CLEAR_INPUT,
   output      logic [sutm_pkg::WORD_W-1:0]   MON_LEVEL,
   output      logic [sutm_pkg::WORD_W-1:0]   INPUT_LOW_POINT,
   output      logic [sutm_pkg::WORD_W-1:0]   INPUT_HIGH_POINT,
   output      logic                          NV_WR,
   output      logic [sutm_pkg::WORD_W-1:0]   NV_WDATA
);
   import sutm_pkg::*;

   localparam int CW = $clog2(ALT_CYCLES + 1);
   localparam int NW = $clog2(NV_LIMIT + 1);
   localparam logic [CW-1:0] ALT_LAST = CW'(ALT_CYCLES - 1);
   localparam logic [NW-1:0] NV_LAST  = NW'(NV_LIMIT - 1);

   if (ALT_CYCLES < 2) begin : g_chk_alt
      $error("ALT_CYCLES must be at least 2");
   end
   if (NV_LIMIT < 1) begin : g_chk_nv
      $error("NV_LIMIT must be at least 1");
   end

   typedef struct packed {
      sutm_state_t              state;
      logic [WORD_W-1:0]        out_word;
      logic [WORD_W-1:0]        seen;
      logic [MODE_W-1:0]        mode;
      logic [WORD_W-1:0]        cmd;
      logic [WORD_W-1:0]        err;
      logic [WORD_W-1:0]        in_word;
      logic [WORD_W-1:0]        rdata;
      logic                     phase;
      logic [CW-1:0]            cnt;
      logic [WORD_W-1:0]        low_pt;
      logic [WORD_W-1:0]        high_pt;
      logic [3:0][WORD_W-1:0]   thr;
      logic [WORD_W-1:0]        shift;
      logic                     shref_prev;
      logic [WORD_W-1:0]        mon;
      logic                     nv_wr;
      logic [WORD_W-1:0]        nv_data;
      logic [NW-1:0]            nv_cnt;
      logic                     nv_full;
   } sutm_regs_t;

   sutm_regs_t s_q;
   sutm_regs_t s_d;

   // Clamps a signed word to the plus or minus 9999 monitor range.
   function automatic logic [WORD_W-1:0] mon_clamp(
      input logic [WORD_W-1:0] v
   );
      logic [WORD_W-1:0] r;
      r = v;
      if ($signed(v) > $signed(MON_POS_MAX)) begin
         r = MON_POS_MAX;
      end else if ($signed(v) < $signed(MON_NEG_MAX)) begin
         r = MON_NEG_MAX;
      end
      return r;
   endfunction : mon_clamp

   // Double dabble: a loop of shifts keeps this small, at the cost of a
   // deeper adder chain, which is harmless at these widths.
   function automatic logic [WORD_W-1:0] to_bcd(
      input logic [BCD_BIN_W-1:0] bin
   );
      logic [WORD_W+BCD_BIN_W-1:0] sh;
      sh = {{WORD_W{1'b0}}, bin};
      for (int i = 0; i < BCD_BIN_W; i++) begin
         for (int j = 0; j < WORD_W / 4; j++) begin
            if (sh[BCD_BIN_W + 4 * j +: 4] > 4'h4) begin
               sh[BCD_BIN_W + 4 * j +: 4] =
                  sh[BCD_BIN_W + 4 * j +: 4] + 4'h3;
            end
         end
         sh = sh << 1;
      end
      return sh[BCD_BIN_W +: WORD_W];
   endfunction : to_bcd

   // Sign word or BCD magnitude of a signed value, saturated at 9999.
   function automatic logic [WORD_W-1:0] alt_word(
      input logic              ph,
      input logic [WORD_W-1:0] v
   );
      logic [WORD_W-1:0] mag;
      mag = v[WORD_W-1] ? WORD_W'(-v) : v;
      if (mag > BCD_MAG_MAX) begin
         mag = BCD_MAG_MAX;
      end
      if (ph) begin
         return to_bcd(mag[BCD_BIN_W-1:0]);
      end
      return v[WORD_W-1] ? RSP_NEG : RSP_POS;
   endfunction : alt_word

   logic [WORD_W:0]   diff;
   logic [WORD_W-1:0] present;
   logic [1:0]        hold;
   logic              chg;
   logic [3:0]        kind;
   logic [3:0]        grp;
   logic [3:0]        sel;
   logic [3:0]        tail;
   logic [3:0]        c_grp;
   logic [3:0]        c_sel;
   logic [WORD_W-1:0] dec_err;
   logic [WORD_W-1:0] alt_src;

   assign diff    = {SCALED_IN[WORD_W-1], SCALED_IN}
                  - {s_q.shift[WORD_W-1], s_q.shift};
   assign present = diff[WORD_W-1:0];
   assign hold    = s_q.mode[MODE_HOLD_LSB +: 2];
   assign chg     = s_q.out_word != s_q.seen;
   assign kind    = s_q.out_word[KIND_LSB +: 4];
   assign grp     = s_q.out_word[GRP_LSB +: 4];
   assign sel     = s_q.out_word[SEL_LSB +: 4];
   assign tail    = s_q.out_word[TAIL_LSB +: 4];
   assign c_grp   = s_q.cmd[GRP_LSB +: 4];
   assign c_sel   = s_q.cmd[SEL_LSB +: 4];

   always_comb begin
      dec_err = CMD_NONE;
      case (grp)
         GRP_SC_TEACH, GRP_SC_READ: begin
            if (sel > SEL_SC_MAX || tail != NIB_ZERO) begin
               dec_err = ERR_PARAM;
            end
         end
         GRP_TH_TEACH, GRP_TH_READ: begin
            if (sel > SEL_TH_MAX || tail != NIB_ZERO) begin
               dec_err = ERR_PARAM;
            end
         end
         GRP_PV_READ: begin
            if (sel != NIB_ZERO || tail != NIB_ZERO) begin
               dec_err = ERR_PARAM;
            end
         end
         default: begin
            dec_err = ERR_NO_CMD;
         end
      endcase
      if (dec_err == CMD_NONE && hold != HOLD_NORMAL &&
          grp != GRP_SC_READ && grp != GRP_TH_READ) begin
         dec_err = ERR_PARAM;
      end
   end

   always_comb begin
      s_d       = s_q;
      s_d.seen  = s_q.out_word;
      s_d.nv_wr = 1'b0;
      s_d.rdata = '0;

      if (REG_WR) begin
         case (REG_ADDR)
            REG_OUT_WORD: s_d.out_word = REG_WDATA;
            REG_MODE:     s_d.mode     = REG_WDATA[MODE_W-1:0];
            default:      s_d.out_word = s_q.out_word;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            REG_OUT_WORD: s_d.rdata = s_q.out_word;
            REG_IN_WORD:  s_d.rdata = s_q.in_word;
            REG_MODE:     s_d.rdata = WORD_W'(s_q.mode);
            REG_STATUS:   s_d.rdata = WORD_W'({s_q.nv_full, s_q.state});
            REG_SHIFT:    s_d.rdata = s_q.shift;
            default:      s_d.rdata = '0;
         endcase
      end

      if (s_q.state == ST_ALT) begin
         if (s_q.cnt == ALT_LAST) begin
            s_d.cnt   = '0;
            s_d.phase = ~s_q.phase;
         end else begin
            s_d.cnt = s_q.cnt + CW'(1);
         end
      end

      // Only a change of the output word moves the sequence.
      if (chg) begin
         if (s_q.state == ST_TEACH && s_q.out_word == CMD_NONE) begin
            s_d.state = ST_IDLE;
            if (c_grp == GRP_SC_TEACH) begin
               // Present input becomes the chosen point.
               if (c_sel[0]) begin
                  s_d.high_pt = RAW_IN;
               end else begin
                  s_d.low_pt = RAW_IN;
               end
            end else begin
               s_d.thr[c_sel[1:0]] = present;
            end
         end else if (kind == CMD_KIND) begin
            // Command space is decoded in every monitor mode.
            s_d.cmd   = s_q.out_word;
            s_d.cnt   = '0;
            s_d.phase = 1'b0;
            if (dec_err != CMD_NONE) begin
               s_d.state = ST_ERR;
               s_d.err   = dec_err;
            end else if (grp == GRP_SC_TEACH || grp == GRP_TH_TEACH) begin
               s_d.state = ST_TEACH;
            end else begin
               s_d.state = ST_ALT;
            end
         end else begin
            // Withdrawn command returns to normal reporting.
            s_d.state = ST_IDLE;
         end
      end

      s_d.shref_prev = SHIFT_REF;
      if (REFERENCE_CLEAR_INPUT) begin
         s_d.shift = '0;
      end else if (SHIFT_REF && !s_q.shref_prev && MEAS_VALID &&
                   hold != HOLD_P2P) begin
         s_d.shift = SCALED_IN;
         if (s_q.mode[MODE_NV_BIT] && !s_q.nv_full) begin
            s_d.nv_wr   = 1'b1;
            s_d.nv_data = SCALED_IN;
            s_d.nv_cnt  = s_q.nv_cnt + NW'(1);
            s_d.nv_full = s_q.nv_cnt == NV_LAST;
         end
      end

      if (s_q.mode[MODE_MON_BIT]) begin
         if (kind != CMD_KIND) begin
            s_d.mon = mon_clamp(s_q.out_word);
         end
      end else begin
         s_d.mon = mon_clamp(present);
      end

      case (s_d.cmd[GRP_LSB +: 4])
         GRP_SC_READ: begin
            alt_src = s_d.cmd[SEL_LSB] ? s_d.high_pt : s_d.low_pt;
         end
         GRP_TH_READ: begin
            alt_src = s_d.thr[s_d.cmd[SEL_LSB +: 2]];
         end
         default: begin
            alt_src = present;
         end
      endcase

      case (s_d.state)
         ST_IDLE:  s_d.in_word = present;
         ST_TEACH: s_d.in_word = s_d.cmd;
         ST_ALT:   s_d.in_word = alt_word(s_d.phase, alt_src);
         ST_ERR:   s_d.in_word = s_d.err;
         default:  s_d.in_word = present;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign REG_RDATA        = s_q.rdata;
   assign MON_LEVEL        = s_q.mon;
   assign INPUT_LOW_POINT  = s_q.low_pt;
   assign INPUT_HIGH_POINT = s_q.high_pt;
   assign NV_WR            = s_q.nv_wr;
   assign NV_WDATA         = s_q.nv_data;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   property p_teach_ok;
      (s_q.state == ST_IDLE && chg && kind == CMD_KIND &&
       grp == GRP_SC_TEACH) |=> (s_q.state == ST_TEACH) ==
      ($past(hold) == HOLD_NORMAL && $past(dec_err) == CMD_NONE);
   endproperty
   a_teach_ok: assert property (p_teach_ok)
      else $error("scaling teach entry does not follow timing hold");

   property p_th_teach_ok;
      (s_q.state == ST_TEACH) |-> s_q.cmd[GRP_LSB +: 4] != GRP_TH_TEACH ||
      $past(hold) == HOLD_NORMAL || $past(s_q.state) == ST_TEACH;
   endproperty
   a_th_teach_ok: assert property (p_th_teach_ok)
      else $error("threshold teach entered outside normal hold");

   property p_echo;
      (s_q.state == ST_TEACH) |-> s_q.in_word == s_q.cmd &&
      s_q.cmd[KIND_LSB +: 4] == CMD_KIND;
   endproperty
   a_echo: assert property (p_echo)
      else $error("teach command not echoed in input word");

   property p_sc_teach;
      (s_q.state == ST_TEACH && chg && s_q.out_word == CMD_NONE &&
       c_grp == GRP_SC_TEACH && !c_sel[0])
      |=> s_q.low_pt == $past(RAW_IN) && s_q.state == ST_IDLE;
   endproperty
   a_sc_teach: assert property (p_sc_teach)
      else $error("lower point not taught from present input");

   property p_th_teach;
      (s_q.state == ST_TEACH && chg && s_q.out_word == CMD_NONE &&
       c_grp == GRP_TH_TEACH)
      |=> s_q.thr[$past(c_sel[1:0])] == $past(present);
   endproperty
   a_th_teach: assert property (p_th_teach)
      else $error("threshold not stored from present data");

   property p_sign;
      (s_q.state == ST_ALT && !s_q.phase) |->
      (s_q.in_word == RSP_POS || s_q.in_word == RSP_NEG);
   endproperty
   a_sign: assert property (p_sign)
      else $error("sign word is neither A000 nor A00F");

   property p_alt_period;
      (s_q.state == ST_ALT && $past(s_q.state) == ST_ALT && !$past(chg) &&
       s_q.phase != $past(s_q.phase)) |-> $past(s_q.cnt) == ALT_LAST;
   endproperty
   a_alt_period: assert property (p_alt_period)
      else $error("alternation toggled before the interval ended");

   property p_no_change;
      !chg |=> s_q.state == $past(s_q.state);
   endproperty
   a_no_change: assert property (p_no_change)
      else $error("command state moved without output word change");

   property p_clear;
      REFERENCE_CLEAR_INPUT |=> s_q.shift == CMD_NONE;
   endproperty
   a_clear: assert property (p_clear)
      else $error("shift applied while reference clear is on");

   property p_p2p;
      (hold == HOLD_P2P && !REFERENCE_CLEAR_INPUT) |=> $stable(s_q.shift);
   endproperty
   a_p2p: assert property (p_p2p)
      else $error("shift applied during peak-to-peak hold");

   property p_clamp;
      $signed(MON_LEVEL) <= $signed(MON_POS_MAX) &&
      $signed(MON_LEVEL) >= $signed(MON_NEG_MAX);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("monitor level outside clamp range");

   property p_cmd_space;
      (s_q.mode[MODE_MON_BIT] && kind == CMD_KIND) |=> $stable(MON_LEVEL);
   endproperty
   a_cmd_space: assert property (p_cmd_space)
      else $error("command word reached the monitor output");

   property p_unknown;
      (chg && kind == CMD_KIND && dec_err == ERR_NO_CMD)
      |=> s_q.in_word == ERR_NO_CMD && s_q.state == ST_ERR;
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unknown command did not answer E000");

   c_teach_done: cover property (s_q.state == ST_TEACH ##1
                                 s_q.state == ST_IDLE);
   c_alt_toggle: cover property (s_q.state == ST_ALT && s_q.phase);
   c_err: cover property (s_q.state == ST_ERR);
   c_nv: cover property (NV_WR);

endmodule : sutm_cmd

// [design/sutm_pkg.sv]
// Constants, codes and types for the sensor unit command interpreter.
// Assumes a single 200 MHz core clock and a host that writes one output
// word and reads one input word through the plain register port.
package sutm_pkg;

   localparam int          WORD_W         = 16;
   localparam int          ADDR_W         = 4;
   localparam int          MODE_W         = 4;
   localparam int          BCD_BIN_W      = 14;
   localparam int          KIND_LSB       = 12;
   localparam int          GRP_LSB        = 8;
   localparam int          SEL_LSB        = 4;
   localparam int          TAIL_LSB       = 0;

   localparam logic [3:0]  CMD_KIND       = 4'hC;
   localparam logic [3:0]  GRP_SC_TEACH   = 4'h5;
   localparam logic [3:0]  GRP_SC_READ    = 4'h6;
   localparam logic [3:0]  GRP_TH_TEACH   = 4'h8;
   localparam logic [3:0]  GRP_TH_READ    = 4'h9;
   localparam logic [3:0]  GRP_PV_READ    = 4'hC;
   localparam logic [3:0]  SEL_SC_MAX     = 4'h1;
   localparam logic [3:0]  SEL_TH_MAX     = 4'h3;
   localparam logic [3:0]  NIB_ZERO       = 4'h0;

   localparam logic [15:0] CMD_NONE       = 16'h0000;
   localparam logic [15:0] RSP_POS        = 16'hA000;
   localparam logic [15:0] RSP_NEG        = 16'hA00F;
   localparam logic [15:0] ERR_NO_CMD     = 16'hE000;
   localparam logic [15:0] ERR_PARAM      = 16'hE001;
   localparam logic [15:0] MON_POS_MAX    = 16'h270F;
   localparam logic [15:0] MON_NEG_MAX    = 16'hD8F1;
   localparam logic [15:0] BCD_MAG_MAX    = 16'h270F;

   localparam logic [1:0]  HOLD_NORMAL    = 2'h0;
   localparam logic [1:0]  HOLD_P2P       = 2'h1;
   localparam int          MODE_HOLD_LSB  = 0;
   localparam int          MODE_MON_BIT   = 2;
   localparam int          MODE_NV_BIT    = 3;

   localparam logic [3:0]  REG_OUT_WORD   = 4'h0;
   localparam logic [3:0]  REG_IN_WORD    = 4'h1;
   localparam logic [3:0]  REG_MODE       = 4'h2;
   localparam logic [3:0]  REG_STATUS     = 4'h3;
   localparam logic [3:0]  REG_SHIFT      = 4'h4;

   localparam int          T_ALT_MS       = 500;
   localparam int          CLK_PERIOD_NS  = 5;
   localparam int          ALT_CYCLES_DEF = T_ALT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int          NV_WRITE_LIMIT = 100000;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_TEACH = 2'b01,
      ST_ALT   = 2'b11,
      ST_ERR   = 2'b10
   } sutm_state_t;

endpackage : sutm_pkg

// [dv/sutm_sensor.sv]
// Behavioural sensor front end and discrete inputs for the bench.
// Assumes the bench sets the wanted levels; they reach the block one
// CORE_CLK edge later, just as a real sampled front end would.
module sutm_sensor (
   input  wire logic                        clk,
   input  wire logic [sutm_pkg::WORD_W-1:0] raw_set,
   input  wire logic [sutm_pkg::WORD_W-1:0] scaled_set,
   input  wire logic                        sample_on,
   input  wire logic                        shift_on,
   input  wire logic                        clear_on,
   output      logic [sutm_pkg::WORD_W-1:0] raw_in,
   output      logic [sutm_pkg::WORD_W-1:0] scaled_in,
   output      logic                        meas_valid,
   output      logic                        shift_ref,
   output      logic                        ref_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   import sutm_pkg::*;

   always @(posedge clk) begin
      raw_in     <= raw_set;
      scaled_in  <= scaled_set;
      meas_valid <= sample_on;
      shift_ref  <= shift_on;
      ref_clear  <= clear_on;
   end
endmodule : sutm_sensor

// [dv/test_sensor_unit_teach_and_monitor_cmds.sv]
// Self-checking bench for the sensor unit command interpreter.
// Assumes sutm_cmd with short counts and the sutm_sensor front end.
module test_sensor_unit_teach_and_monitor_cmds;
   timeunit 1ns;
   timeprecision 1ps;
   import sutm_pkg::*;
   localparam int ALT = 8;
   localparam int NVL = 3;
   logic              clk = 1'b0;
   logic              srst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [15:0]       wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [15:0]       rdata, mon, lowp, highp, nvwd, scaled, raw;
   logic              nvwr, valid, shref, clr;
   logic [15:0]       raw_set = 16'h0123;
   logic [15:0]       sc_set = 16'h0100;
   logic              smp = 1'b1;
   logic              sh = 1'b0;
   logic              cl = 1'b0;
   logic [15:0]       d;
   int                n_mismatch = 0;
   int                check_count = 0;
   int                cyc = 0;
   int                nv_cnt = 0;
   logic [15:0] thv [4] = '{16'hD8F1, 16'h0100, 16'h03E8, 16'h1234};
   logic [15:0] ths [4] = '{16'hA00F, 16'hA000, 16'hA000, 16'hA000};
   logic [15:0] thm [4] = '{16'h9999, 16'h0256, 16'h1000, 16'h4660};
   logic [15:0] mw [8] = '{16'h270F, 16'h2710, 16'h7FFF, 16'hD8F1,
                           16'hD8F0, 16'h8000, 16'h0000, 16'h1234};
   logic [15:0] me [8] = '{16'h270F, 16'h270F, 16'h270F, 16'hD8F1,
                           16'hD8F1, 16'hD8F1, 16'h0000, 16'h1234};

   always #2.5 clk = ~clk;

   sutm_cmd #(.ALT_CYCLES(ALT), .NV_LIMIT(NVL)) u_sutm_cmd (
      .CORE_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .SCALED_IN(scaled),
      .RAW_IN(raw), .MEAS_VALID(valid), .SHIFT_REF(shref),
      .REFERENCE_CLEAR_INPUT(clr), .MON_LEVEL(mon),
      .INPUT_LOW_POINT(lowp), .INPUT_HIGH_POINT(highp),
      .NV_WR(nvwr), .NV_WDATA(nvwd));

   sutm_sensor u_sutm_sensor (
      .clk(clk), .raw_set(raw_set), .scaled_set(sc_set),
      .sample_on(smp), .shift_on(sh), .clear_on(cl), .raw_in(raw),
      .scaled_in(scaled), .meas_valid(valid), .shift_ref(shref),
      .ref_clear(clr));

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // The strobe is dropped at the taking edge, so calls may follow at once.
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
      chk(d, exp);
   endtask : rd_chk

   task automatic cmd(input logic [15:0] w, input logic [15:0] exp);
      wr_reg(REG_OUT_WORD, w);
      rd_chk(REG_IN_WORD, exp);
   endtask : cmd

   task automatic sread(input logic [15:0] c, input logic [15:0] sg,
                        input logic [15:0] mag, input logic [15:0] pres);
      cmd(c, sg);
      repeat (ALT - 2) @(posedge clk);
      rd_chk(REG_IN_WORD, mag);
      repeat (ALT - 2) @(posedge clk);
      rd_chk(REG_IN_WORD, sg);
      cmd(CMD_NONE, pres);
   endtask : sread

   always @(posedge clk) begin
      if (nvwr === 1'b1) begin
         nv_cnt++;
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rd_chk(REG_MODE, 16'h0000);
      rd_chk(REG_IN_WORD, 16'h0100);
      rd_chk(4'h7, 16'h0000);
      chk(lowp, 16'h0000);
      cmd(16'hC500, 16'hC500);
      raw_set <= 16'h0193;
      cmd(CMD_NONE, 16'h0100);
      chk(lowp, 16'h0193);
      cmd(16'hC510, 16'hC510);
      raw_set <= 16'h07C9;
      cmd(CMD_NONE, 16'h0100);
      chk(highp, 16'h07C9);
      sread(16'hC600, RSP_POS, 16'h0403, 16'h0100);
      sread(16'hC610, RSP_POS, 16'h1993, 16'h0100);
      for (int i = 0; i < 4; i++) begin
         sc_set <= thv[i];
         cmd({CMD_KIND, GRP_TH_TEACH, 4'(i), 4'h0},
             {CMD_KIND, GRP_TH_TEACH, 4'(i), 4'h0});
         cmd(CMD_NONE, thv[i]);
      end
      for (int i = 0; i < 4; i++) begin
         sread({CMD_KIND, GRP_TH_READ, 4'(i), 4'h0},
               ths[i], thm[i], 16'h1234);
      end
      wr_reg(REG_MODE, 16'h0001);
      cmd(16'hC500, ERR_PARAM);
      cmd(16'hC830, ERR_PARAM);
      cmd(16'hCC00, ERR_PARAM);
      cmd(CMD_NONE, 16'h1234);
      // The front end adds one edge and the edge detector one more.
      sh <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(REG_SHIFT, 16'h0000);
      sh <= 1'b0;
      wr_reg(REG_MODE, 16'h0000);
      cmd(16'hCE00, ERR_NO_CMD);
      cmd(16'hC520, ERR_PARAM);
      cmd(16'hC501, ERR_PARAM);
      cmd(CMD_NONE, 16'h1234);
      sc_set <= 16'hFB2E;
      sread(16'hCC00, RSP_NEG, 16'h1234, 16'hFB2E);
      sc_set <= 16'h2710;
      sread(16'hCC00, RSP_POS, 16'h9999, 16'h2710);
      cmd(16'hCC00, RSP_POS);
      wr_reg(REG_OUT_WORD, 16'hCC00);
      rd_chk(REG_IN_WORD, 16'h9999);
      cmd(CMD_NONE, 16'h2710);
      sc_set <= 16'h0300;
      sh <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(REG_SHIFT, 16'h0300);
      rd_chk(REG_IN_WORD, 16'h0000);
      sc_set <= 16'h0350;
      repeat (2) @(posedge clk);
      rd_chk(REG_IN_WORD, 16'h0050);
      sh <= 1'b0;
      smp <= 1'b0;
      sc_set <= 16'h0400;
      repeat (2) @(posedge clk);
      sh <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(REG_SHIFT, 16'h0300);
      sh <= 1'b0;
      smp <= 1'b1;
      cl <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(REG_SHIFT, 16'h0000);
      sh <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(REG_SHIFT, 16'h0000);
      cl <= 1'b0;
      repeat (2) @(posedge clk);
      rd_chk(REG_SHIFT, 16'h0000);
      sh <= 1'b0;
      chk(16'(nv_cnt), 16'h0000);
      wr_reg(REG_MODE, 16'h0008);
      for (int k = 1; k <= 4; k++) begin
         sc_set <= 16'(16 * k);
         sh <= 1'b1;
         repeat (3) @(posedge clk);
         sh <= 1'b0;
         repeat (3) @(posedge clk);
      end
      chk(16'(nv_cnt), 16'(NVL));
      chk(nvwd, 16'h0030);
      @(posedge clk);
      addr <= REG_STATUS;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({15'h0000, rdata[2]}, 16'h0001);
      cl <= 1'b1;
      wr_reg(REG_MODE, 16'h0004);
      for (int i = 0; i < 8; i++) begin
         wr_reg(REG_OUT_WORD, mw[i]);
         chk(mon, me[i]);
      end
      wr_reg(REG_OUT_WORD, 16'hC500);
      chk(mon, 16'h1234);
      rd_chk(REG_IN_WORD, 16'hC500);
      sc_set <= 16'h0777;
      cmd(CMD_NONE, 16'h0777);
      wr_reg(REG_MODE, 16'h0000);
      chk(mon, 16'h0777);
      end_of_test();
   end
endmodule : test_sensor_unit_teach_and_monitor_cmds
